// ==== core/fsf_consts.svh ====
// Offsets, field positions, reset values and timing figures of the filter back end
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH
`define FSF_OFF_CFG 4'h0
`define FSF_OFF_CHEN 4'h4
`define FSF_OFF_STAT 4'h8
`define FSF_OFF_DATA 4'hc
`define FSF_CFG_RATE_LSB 0
`define FSF_CFG_FILT_LSB 11
`define FSF_CFG_PWR_LSB 14
`define FSF_CFG_POST_LSB 16
`define FSF_RATE_RST 11'h180
`define FSF_FILT_RST 3'h4
`define FSF_PWR_RST 2'h2
`define FSF_POST_RST 2'h1
`define FSF_CHEN_RST 8'h01
`define FSF_FILT_FAST 3'h4
`define FSF_FILT_POST 3'h7
`define FSF_PWR_LOW 2'h0
`define FSF_PWR_MID 2'h1
`define FSF_DEC_BASE 32
`define FSF_AVG_FULL 16
`define FSF_AVG_LOW 8
`define FSF_SINC_SETTLE 3
`define FSF_DEAD_FIRST 95
`define FSF_DEAD_SEQ 30
`define FSF_CORE_HZ 20000000
`define FSF_FCLK_FULL_HZ 614400
`define FSF_FCLK_MID_HZ 153600
`define FSF_FCLK_LOW_HZ 76800
`define FSF_PHASE_BITS 24
`define FSF_SETTLE_US_FULL {32'd38498, 32'd41831, 32'd51831, 32'd61831}
`define FSF_SETTLE_US_MID {32'd38998, 32'd42331, 32'd52331, 32'd62331}
`define FSF_SETTLE_US_LOW {32'd39662, 32'd42995, 32'd52995, 32'd62995}
`define FSF_PERIOD_US {32'd36670, 32'd40000, 32'd50000, 32'd60000}
`define FSF_US_PER_S 1000000
`endif

// ==== core/fsf_filter.sv ====
// Fast settling and post filter decimation back end with Wishbone registers
//
// Operation
// [R1] Fast code adds averaging after sinc3
// [R2] Average 16 full/mid, 8 low power
// [R3] Continuous word every avg*32*rate ticks
// [R4] Master tick rate follows power mode
// [R5] Rate divider 1..2047, zero write ignored
// [R6] First result (2+avg)*32*rate+95 ticks
// [R7] Steady output rate through channel changes; the code restarts the filter on every channel change
// [R8] No step detection; conversions simply continue
// [R9] Sequencer cycles enabled channels, full first settle
// [R10] Later sequenced conversions use dead 30
// [R11] Sinc notch at rate*32, averaging adds more
// [R12] All-ones code selects post filter path
// [R13] Four post rates with table settle times
// [R14] Post: full settle first, then per period
// [R15] Post: every channel change waits settle
// [R16] One-cycle valid strobe per settled word
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "fsf_consts.svh"

module fsf_fifo #(
    parameter int W = 27,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [AW:0] level
);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic do_push;
    logic do_pop;

    // Honest flags from the occupancy count
    assign in_ready = cnt_ff < (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rp_ff];
    assign level = cnt_ff;
    assign do_push = ce && in_valid && in_ready;
    assign do_pop = ce && out_ready && out_valid;

    // Storage written by index
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (do_push) begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (do_pop) begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // fsf_fifo

module fsf_filter #(
    parameter int TICK_DIV = 1,
    parameter logic [23:0] STEP_FULL = 24'((64'(`FSF_FCLK_FULL_HZ) << `FSF_PHASE_BITS) / `FSF_CORE_HZ),
    parameter logic [23:0] STEP_MID = 24'((64'(`FSF_FCLK_MID_HZ) << `FSF_PHASE_BITS) / `FSF_CORE_HZ),
    parameter logic [23:0] STEP_LOW = 24'((64'(`FSF_FCLK_LOW_HZ) << `FSF_PHASE_BITS) / `FSF_CORE_HZ),
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Modulator bitstream pin
    input wire logic MOD_BIT,
    // Result stream
    output logic RESULT_VALID,
    output fsf_pkg::result_t RESULT_DATA,
    output logic [2:0] ACTIVE_CHAN
);
    import fsf_pkg::*;
    localparam int W = 52;
    localparam int FAW = $clog2(FIFO_DEPTH);

    logic [10:0] rate_ff;
    logic [2:0] filt_ff;
    logic [1:0] pwr_ff;
    logic [1:0] post_ff;
    logic [7:0] chen_ff;
    logic [2:0] ch_ff;
    logic mod_s1_ff, mod_s2_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [24:0] ph_ff;
    logic [15:0] dec_cnt_ff;
    logic [4:0] sinc_idx_ff;
    logic [4:0] avg_cnt_ff;
    logic signed [W-1:0] integ_ff [3];
    logic signed [W-1:0] dly_ff [3];
    logic signed [W+3:0] acc_ff;
    logic signed [W+3:0] hold_ff;
    logic dead_on_ff;
    logic [6:0] dead_cnt_ff;
    logic seq_ff;
    logic [16:0] post_cnt_ff;
    logic post_first_ff;
    state_t state_ff;
    logic valid_ff;
    result_t res_ff;

    logic go, wr_go, rd_data, sw_restart, run_ok, fast, post;
    logic tick, sinc_stb, rdy, push, multi, seq_adv, restart, stall;
    logic [31:0] wmask, wnew, rd_mux;
    logic [15:0] dec_lim;
    logic [4:0] avg_lim;
    logic [6:0] dead_lim;
    logic [23:0] step;
    logic [2:0] nxt_ch, low_ch;
    logic signed [W-1:0] comb_v [4];
    logic fifo_in_ready, fifo_out_valid;
    result_t fifo_out;
    logic [FAW:0] fifo_level;

    // Post filter tick count from a time in microseconds, rounded up, then divided by TICK_DIV rounding down
    function automatic logic [16:0] us_ticks(input logic [31:0] us, input logic [1:0] pm);
        logic [63:0] hz;
        hz = (pm == `FSF_PWR_LOW) ? 64'(`FSF_FCLK_LOW_HZ) :
             (pm == `FSF_PWR_MID) ? 64'(`FSF_FCLK_MID_HZ) : 64'(`FSF_FCLK_FULL_HZ);
        return 17'((64'(us) * hz + 64'(`FSF_US_PER_S - 1)) / 64'(`FSF_US_PER_S) / 64'(TICK_DIV));
    endfunction

    // Next enabled channel after a given one, wrapping round
    function automatic logic [2:0] next_en(input logic [7:0] en, input logic [2:0] cur);
        logic [2:0] r;
        logic [2:0] c;
        r = cur;
        for (int i = 7; i >= 1; i--) begin
            c = cur + 3'(i);
            if (en[c]) begin
                r = c;
            end
        end
        return r;
    endfunction

    // Pin synchroniser for the modulator bit
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mod_s1_ff <= 1'b0;
            mod_s2_ff <= 1'b0;
        end else if (CE) begin
            mod_s1_ff <= MOD_BIT;
            mod_s2_ff <= mod_s1_ff;
        end
    end

    // Bus decode; registered ack gives one wait state
    assign go = WB_CYC_I && WB_STB_I && !ack_ff && CE;
    assign wr_go = go && WB_WE_I;
    assign rd_data = go && !WB_WE_I && (WB_ADR_I == `FSF_OFF_DATA);
    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign sw_restart = wr_go && ((WB_ADR_I == `FSF_OFF_CFG) || (WB_ADR_I == `FSF_OFF_CHEN));
    always_comb begin
        wnew = '0;
        rd_mux = '0;
        if (WB_ADR_I == `FSF_OFF_CFG) begin
            rd_mux = {14'h0, post_ff, pwr_ff, filt_ff, rate_ff};
        end else if (WB_ADR_I == `FSF_OFF_CHEN) begin
            rd_mux = {24'h0, chen_ff};
        end else if (WB_ADR_I == `FSF_OFF_STAT) begin
            rd_mux = {17'h0, 5'(fifo_level), 6'h0, state_ff != ST_IDLE, ch_ff};
        end else if (WB_ADR_I == `FSF_OFF_DATA) begin
            rd_mux = fifo_out_valid ? {5'h0, fifo_out} : 32'h0;
        end
        wnew = (rd_mux & ~wmask) | (WB_DAT_I & wmask);
    end

    // Ack and read data; unmapped reads answer zero
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else if (CE) begin
            ack_ff <= go;
            if (go) begin
                rdat_ff <= WB_WE_I ? 32'h0 : rd_mux;
            end
        end
    end
    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;

    // Configuration registers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rate_ff <= `FSF_RATE_RST;
            filt_ff <= `FSF_FILT_RST;
            pwr_ff <= `FSF_PWR_RST;
            post_ff <= `FSF_POST_RST;
            chen_ff <= `FSF_CHEN_RST;
        end else if (wr_go && WB_ADR_I == `FSF_OFF_CFG) begin
            // [R5] zero divider refused
            if (wnew[`FSF_CFG_RATE_LSB +: 11] != 11'h0) begin
                rate_ff <= wnew[`FSF_CFG_RATE_LSB +: 11];
            end
            filt_ff <= wnew[`FSF_CFG_FILT_LSB +: 3];
            pwr_ff <= wnew[`FSF_CFG_PWR_LSB +: 2];
            post_ff <= wnew[`FSF_CFG_POST_LSB +: 2];
        end else if (wr_go && WB_ADR_I == `FSF_OFF_CHEN) begin
            chen_ff <= wnew[7:0];
        end
    end

    // [R1] [R12] filter path select
    assign fast = filt_ff == `FSF_FILT_FAST;
    assign post = filt_ff == `FSF_FILT_POST;
    assign run_ok = (fast || post) && (chen_ff != 8'h0);
    // [R2] averaging count by power mode
    assign avg_lim = 5'((pwr_ff == `FSF_PWR_LOW) ? `FSF_AVG_LOW - 1 : `FSF_AVG_FULL - 1);
    // [R10] sequenced dead time
    assign dead_lim = 7'(seq_ff ? `FSF_DEAD_SEQ - 1 : `FSF_DEAD_FIRST - 1);
    // [R11] decimation by 32 times divider
    assign dec_lim = 16'(rate_ff * `FSF_DEC_BASE) - 16'h1;
    // [R4] master tick rate by power mode
    assign step = (pwr_ff == `FSF_PWR_LOW) ? STEP_LOW : (pwr_ff == `FSF_PWR_MID) ? STEP_MID : STEP_FULL;

    localparam logic [127:0] PERIOD_TAB = `FSF_PERIOD_US;
    logic [16:0] post_target;
    logic [127:0] settle_tab;
    // [R13] [R14] settle first, then period
    always_comb begin
        settle_tab = (pwr_ff == `FSF_PWR_LOW) ? `FSF_SETTLE_US_LOW :
                     (pwr_ff == `FSF_PWR_MID) ? `FSF_SETTLE_US_MID : `FSF_SETTLE_US_FULL;
        post_target = post_first_ff ? us_ticks(settle_tab[(3 - post_ff) * 32 +: 32], pwr_ff) :
                      us_ticks(PERIOD_TAB[(3 - post_ff) * 32 +: 32], pwr_ff);
    end

    // Channel sequencing helpers
    assign multi = (chen_ff & (chen_ff - 8'h1)) != 8'h0;
    assign low_ch = next_en(chen_ff, 3'h7);
    assign nxt_ch = next_en(chen_ff, ch_ff);
    assign push = (state_ff == ST_PEND) && fifo_in_ready && CE;
    assign stall = (state_ff == ST_PEND) && !fifo_in_ready;
    // [R9] [R15] sequencer moves on after each word
    assign seq_adv = push && multi;
    assign restart = sw_restart || seq_adv || (state_ff == ST_IDLE);
    assign tick = ph_ff[24] && CE && (state_ff != ST_IDLE) && !stall && !restart;
    assign sinc_stb = tick && (dec_cnt_ff == dec_lim);

    // Master clock tick from a phase accumulator
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ph_ff <= '0;
        end else if (CE) begin
            ph_ff <= {1'b0, ph_ff[23:0]} + {1'b0, step};
        end
    end

    // Sinc3 comb chain evaluated at each decimation point
    always_comb begin
        comb_v[0] = integ_ff[2];
        for (int i = 0; i < 3; i++) begin
            comb_v[i+1] = comb_v[i] - dly_ff[i];
        end
    end

    // [R11] sinc3 integrators and combs
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || (CE && restart)) begin
            for (int i = 0; i < 3; i++) begin
                integ_ff[i] <= '0;
                dly_ff[i] <= '0;
            end
            dec_cnt_ff <= '0;
            sinc_idx_ff <= '0;
        end else if (tick) begin
            integ_ff[0] <= integ_ff[0] + (mod_s2_ff ? W'(1) : -W'(1));
            for (int i = 1; i < 3; i++) begin
                integ_ff[i] <= integ_ff[i] + integ_ff[i-1];
            end
            dec_cnt_ff <= sinc_stb ? 16'h0 : dec_cnt_ff + 16'h1;
            if (sinc_stb) begin
                for (int i = 0; i < 3; i++) begin
                    dly_ff[i] <= comb_v[i];
                end
                sinc_idx_ff <= (sinc_idx_ff == 5'h1f) ? sinc_idx_ff : sinc_idx_ff + 5'h1;
            end
        end
    end

    // [R3] [R6] averaging after the sinc settles
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || (CE && restart)) begin
            acc_ff <= '0;
            avg_cnt_ff <= '0;
            hold_ff <= '0;
        end else if (sinc_stb && fast && sinc_idx_ff >= 5'(`FSF_SINC_SETTLE - 1)) begin
            acc_ff <= (avg_cnt_ff == avg_lim) ? '0 : acc_ff + (W+4)'(comb_v[3]);
            avg_cnt_ff <= (avg_cnt_ff == avg_lim) ? 5'h0 : avg_cnt_ff + 5'h1;
            if (avg_cnt_ff == avg_lim) begin
                hold_ff <= acc_ff + (W+4)'(comb_v[3]);
            end
        end else if (tick && post && post_cnt_ff == post_target - 17'h1) begin
            // Post path: boxcar of sinc outputs over the period
            hold_ff <= acc_ff;
            acc_ff <= '0;
        end else if (sinc_stb && post) begin
            acc_ff <= acc_ff + (W+4)'(comb_v[3]);
        end
    end

    // [R6] dead time after each averaged batch
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || (CE && restart)) begin
            dead_on_ff <= 1'b0;
            dead_cnt_ff <= '0;
        end else if (sinc_stb && fast && sinc_idx_ff >= 5'(`FSF_SINC_SETTLE - 1) && avg_cnt_ff == avg_lim) begin
            dead_on_ff <= 1'b1;
            dead_cnt_ff <= dead_lim;
        end else if (tick && dead_on_ff) begin
            dead_on_ff <= dead_cnt_ff != 7'h0;
            dead_cnt_ff <= dead_cnt_ff - 7'h1;
        end
    end

    // [R14] [R15] post path settle and period counter
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || (CE && restart)) begin
            post_cnt_ff <= '0;
            post_first_ff <= 1'b1;
        end else if (tick && post) begin
            if (post_cnt_ff == post_target - 17'h1) begin
                post_cnt_ff <= '0;
                post_first_ff <= 1'b0;
            end else begin
                post_cnt_ff <= post_cnt_ff + 17'h1;
            end
        end
    end

    // [R7] [R8] ready word; no step detection, runs on
    assign rdy = tick && ((fast && dead_on_ff && dead_cnt_ff == 7'h0) ||
                          (post && post_cnt_ff == post_target - 17'h1));

    // Conversion state
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
        end else if (CE) begin
            case (state_ff)
                ST_IDLE: begin
                    state_ff <= run_ok ? ST_CONV : ST_IDLE;
                end
                ST_CONV: begin
                    state_ff <= !run_ok ? ST_IDLE : rdy ? ST_PEND : ST_CONV;
                end
                ST_PEND: begin
                    state_ff <= !run_ok ? ST_IDLE : (push || sw_restart) ? ST_CONV : ST_PEND;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // [R9] [R10] channel pointer and sequence flag
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ch_ff <= 3'h0;
            seq_ff <= 1'b0;
        end else if (CE) begin
            if (sw_restart || state_ff == ST_IDLE) begin
                ch_ff <= low_ch;
                seq_ff <= 1'b0;
            end else if (seq_adv) begin
                ch_ff <= nxt_ch;
                seq_ff <= 1'b1;
            end
        end
    end

    // [R16] one-cycle strobe with the pushed word
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            valid_ff <= 1'b0;
            res_ff <= '0;
        end else if (CE) begin
            valid_ff <= push;
            if (push) begin
                res_ff <= '{chan: ch_ff, data: hold_ff[W+3 -: 24]};
            end
        end
    end
    assign RESULT_VALID = valid_ff;
    assign RESULT_DATA = res_ff;
    assign ACTIVE_CHAN = ch_ff;

    // Full FIFO holds the word and freezes conversion timing
    fsf_fifo #(.W($bits(result_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ce(CE),
        .in_valid(state_ff == ST_PEND),
        .in_ready(fifo_in_ready),
        .in_data({ch_ff, hold_ff[W+3 -: 24]}),
        .out_valid(fifo_out_valid),
        .out_ready(rd_data),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    chk_rate_nonzero: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) rate_ff != 11'h0) // [R5]
        else $error("rate divider reached zero");
    chk_avg_count: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (pwr_ff == 2'h0) |-> (avg_lim == 5'd7)) // [R2]
        else $error("low power average count wrong");
    chk_valid_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $rose(RESULT_VALID) && CE |=> !RESULT_VALID) // [R16]
        else $error("valid strobe longer than one cycle");
    chk_dead_first: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        sw_restart |=> (dead_lim == 7'd94)) // [R6]
        else $error("first dead time not 95");
    chk_dead_seq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        seq_adv && !sw_restart |=> (dead_lim == 7'd29)) // [R10]
        else $error("sequenced dead time not 30");
    chk_sinc_period: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        sinc_stb |=> (dec_cnt_ff == 16'h0)) // [R11]
        else $error("decimation counter did not wrap");
    chk_fast_settled: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        push && fast |-> (sinc_idx_ff >= 5'(avg_lim) + 5'd3)) // [R6]
        else $error("fast word pushed before settling");
    chk_restart_clear: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        sw_restart && CE |=> (sinc_idx_ff == 5'h0) && !dead_on_ff && post_first_ff) // [R15]
        else $error("channel change did not restart filter");
endmodule // fsf_filter

// ==== core/fsf_pkg.sv ====
// Types shared by the filter back end
package fsf_pkg;
    typedef struct packed {
        logic [2:0] chan;
        logic [23:0] data;
    } result_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_PEND = 3'b100
    } state_t;
endpackage

// ==== sim/fsf_filter_bench.sv ====
// Self-checking bench for the filter back end
`timescale 1ns/1ps
`include "fsf_consts.svh"

module fsf_filter_bench;
    import fsf_pkg::*;
    typedef struct {
        logic [1:0] pwr;
        logic [10:0] rate;
        int first;
        int period;
    } row_t;
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CE = 1'b1;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [3:0] WB_ADR_I = 4'h0;
    logic [3:0] WB_SEL_I = 4'hf;
    logic [31:0] WB_DAT_I = 32'h0;
    logic [31:0] WB_DAT_O;
    logic WB_ACK_O;
    logic MOD_BIT;
    logic RESULT_VALID;
    result_t RESULT_DATA;
    logic [2:0] ACTIVE_CHAN;
    logic [7:0] level = 8'h40;
    logic [31:0] rd;
    logic [2:0] ch;
    int n_errors = 0;
    int checked = 0;
    int now = 0;
    int n_words = 0;
    int t0, t1, t2, w0;
    int settle_us [4] = '{38498, 41831, 51831, 61831};
    row_t rows [4];

    // 50 ns clock, cycle count and strobe count
    always #25 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        now <= now + 1;
        if (RESULT_VALID === 1'b1) n_words <= n_words + 1;
    end

    // Fast ticks: 2, 4 and 8 core cycles per master tick
    fsf_filter #(
        .TICK_DIV(128),
        .STEP_FULL(24'h800000),
        .STEP_MID(24'h400000),
        .STEP_LOW(24'h200000),
        .FIFO_DEPTH(16)
    ) DUT (
        .CORE_CLK(CORE_CLK),
        .SYS_RST(SYS_RST),
        .CE(CE),
        .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O),
        .MOD_BIT(MOD_BIT),
        .RESULT_VALID(RESULT_VALID),
        .RESULT_DATA(RESULT_DATA),
        .ACTIVE_CHAN(ACTIVE_CHAN)
    );

    fsf_mod_src MOD (.clk(CORE_CLK), .level(level), .mod_bit(MOD_BIT));

    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic near(input int seen, input int exp, input int tol);
        check(seen >= exp - tol && seen <= exp + tol, 1);
    endtask

    // Classic cycle held until ack is sampled, then one idle cycle
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= dat;
        do begin
            @(posedge CORE_CLK);
        end while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        t0 = now;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CORE_CLK);
    endtask

    // Next result strobe; the strobe must be gone a cycle later
    task automatic word(output int t, output logic [2:0] c);
        do begin
            @(posedge CORE_CLK);
        end while (RESULT_VALID !== 1'b1);
        t = now;
        c = RESULT_DATA.chan;
        @(posedge CORE_CLK);
        check(RESULT_VALID, 0);
    endtask

    // Consumer pops everything; reads of an empty queue are harmless
    task automatic drain;
        repeat (17) wb(1'b0, `FSF_OFF_DATA, 32'h0);
    endtask

    function automatic logic [31:0] cfg(logic [1:0] p, logic [2:0] f, logic [1:0] s, logic [10:0] r);
        return (32'(s) << `FSF_CFG_POST_LSB) | (32'(p) << `FSF_CFG_PWR_LSB) | (32'(f) << `FSF_CFG_FILT_LSB) | 32'(r);
    endfunction

    // Post time in core cycles: full power ticks, divided by 128, 2 cycles per tick
    function automatic int post_cyc(input int us);
        return int'(longint'(us) * `FSF_FCLK_FULL_HZ / `FSF_US_PER_S / 128 * 2);
    endfunction

    initial begin
        // Cycles: first ((2+avg)*32*rate+95)*tick, period avg*32*rate*tick
        rows[0] = '{2'h2, 11'd1, 1342, 1024};
        rows[1] = '{2'h1, 11'd1, 2684, 2048};
        rows[2] = '{2'h0, 11'd1, 3320, 2048};
        rows[3] = '{2'h2, 11'd2, 2494, 2048};
        repeat (8) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        @(posedge CORE_CLK);
        wb(1'b0, `FSF_OFF_CFG, 32'h0);
        check(rd, 32'h0001a180);
        wb(1'b0, `FSF_OFF_CHEN, 32'h0);
        check(rd, 32'h00000001);
        foreach (rows[i]) begin
            level <= 8'h40;
            drain();
            wb(1'b1, `FSF_OFF_CFG, cfg(rows[i].pwr, `FSF_FILT_FAST, 2'h1, rows[i].rate));
            word(t1, ch);
            near(t1 - t0, rows[i].first, 20);
            level <= 8'hc0;
            word(t2, ch);
            near(t2 - t1, rows[i].period, 2);
            check(ch, 0);
        end
        // Sequencer over channels 0 and 2, later words with dead time 30
        drain();
        wb(1'b1, `FSF_OFF_CHEN, 32'h5);
        wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_FAST, 2'h1, 11'd1));
        word(t1, ch);
        near(t1 - t0, 1342, 20);
        check(ch, 0);
        word(t2, ch);
        near(t2 - t1, 1212, 2);
        check(ch, 2);
        word(t1, ch);
        near(t1 - t2, 1212, 2);
        check(ch, 0);
        // Every post rate, settle in core cycles scaled down by 128
        wb(1'b1, `FSF_OFF_CHEN, 32'h1);
        for (int s = 0; s < 4; s++) begin
            drain();
            wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_POST, 2'(s), 11'd1));
            word(t1, ch);
            near(t1 - t0, post_cyc(settle_us[s]), 6);
            if (s == 0) begin
                word(t2, ch);
                near(t2 - t1, post_cyc(36670), 6);
            end
        end
        // Two channels under post filter: each word waits the settle time
        drain();
        wb(1'b1, `FSF_OFF_CHEN, 32'h3);
        wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_POST, 2'h0, 11'd1));
        word(t1, ch);
        word(t2, ch);
        near(t2 - t1, post_cyc(settle_us[0]), 6);
        check(ch, 1);
        // Fill the queue without popping; drain after the restart so no stale word stays
        wb(1'b1, `FSF_OFF_CHEN, 32'h1);
        wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_FAST, 2'h1, 11'd1));
        drain();
        repeat (16) word(t1, ch);
        w0 = n_words;
        repeat (2100) @(posedge CORE_CLK);
        check(n_words - w0, 0);
        wb(1'b0, `FSF_OFF_STAT, 32'h0);
        check(rd[14:10], 16);
        for (int k = 0; k < 17; k++) begin
            wb(1'b0, `FSF_OFF_DATA, 32'h0);
            check(rd[26:24], 0);
        end
        wb(1'b0, `FSF_OFF_DATA, 32'h0);
        check(rd, 0);
        // A zero rate write keeps the old rate
        wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_FAST, 2'h1, 11'd5));
        wb(1'b1, `FSF_OFF_CFG, cfg(2'h2, `FSF_FILT_FAST, 2'h1, 11'd0));
        wb(1'b0, `FSF_OFF_CFG, 32'h0);
        check(rd[10:0], 5);
        // Reset in mid-run clears outputs and restores the reset settings
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        @(posedge CORE_CLK);
        check({RESULT_VALID, ACTIVE_CHAN, RESULT_DATA}, 0);
        wb(1'b0, `FSF_OFF_CFG, 32'h0);
        check(rd, 32'h0001a180);
        close_out();
    end

    // Hang guard, well past the expected run length
    initial begin
        #(60000 * 50);
        n_errors++;
        close_out();
    end
endmodule // fsf_filter_bench

// ==== sim/fsf_mod_src.sv ====
// Modulator stand-in: first-order bitstream whose ones density follows a level
`timescale 1ns/1ps

module fsf_mod_src (
    // Clock and input level
    input wire logic clk,
    input wire logic [7:0] level,
    // Bitstream pin
    output logic mod_bit
);
    logic [8:0] acc_ff = 9'h000;

    // Carry out is the bit; a level step just bends the density, no framing
    always_ff @(posedge clk) begin
        acc_ff <= {1'b0, acc_ff[7:0]} + {1'b0, level};
    end
    assign mod_bit = acc_ff[8];
endmodule // fsf_mod_src
